// ===== rtl/ibpo_top.sv
// Input bias register and digital pin option logic with Wishbone access
`timescale 1ns/10ps
module ibpo_top #(
    parameter int DATA_W = 24
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire ibpo_pkg::ibpo_wb_req_type wb_req_i,
    output      ibpo_pkg::ibpo_wb_rsp_type wb_rsp_o,
    input  wire logic                      cs_n_i,
    input  wire logic                      external_clock_input_i,
    input  wire logic                      start_pin_i,
    input  wire logic                      reset_pin_n_i,
    input  wire logic                      power_down_pin_n_i,
    input  wire logic                      serial_busy_i,
    input  wire logic                      serial_dout_i,
    input  wire logic                      conv_valid_i,
    input  wire logic [DATA_W-1:0]         conv_data_i,
    output      logic                      conv_run_o,
    output      logic                      internal_osc_sel_o,
    output      logic                      serial_enable_o,
    output      logic                      power_down_o,
    output      logic                      ready_output_n_o,
    output      logic                      dual_serial_ready_output_o,
    output      logic                      dual_serial_ready_output_oe_o,
    output      ibpo_pkg::ibpo_bias_type   bias_o
);
    import ibpo_pkg::*;

    typedef struct packed {
        ibpo_fsm_type            fsm;
        logic [7:0]              bias;
        logic                    cont_mode;
        logic                    sw_pdown;
        logic                    ready;
        logic [DATA_W-1:0]       result;
        logic                    ext_clk_q;
        logic [IDLE_CNT_W-1:0]   idle_cnt;
        logic                    internal_osc;
        logic                    ack;
        logic [31:0]             rdata;
        logic                    dout;
        logic                    ready_n;
        ibpo_bias_type           bias_drv;
    } ibpo_state_type;

    localparam logic [IDLE_CNT_W-1:0] IDLE_MAX = IDLE_CNT_W'(CLK_IDLE_CYCLES);

    function automatic ibpo_state_type ibpo_reset_state();
        ibpo_state_type r;
        r              = '0;
        r.fsm          = ST_IDLE;
        r.bias         = BIAS_RESET;
        r.internal_osc = 1'b1;
        r.ready_n      = 1'b1;
        r.dout         = 1'b1;
        return r;
    endfunction

    ibpo_state_type s;
    ibpo_state_type next_s;

    logic       access;
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic       start_cmd;
    logic       stop_cmd;
    logic       reset_cmd;
    logic       pdown;
    logic       free_run;
    logic       new_result;
    logic       data_read;

    always_comb begin
        access    = wb_req_i.cyc && wb_req_i.stb && !s.ack;
        wr        = access && wb_req_i.we && wb_req_i.sel[0];
        rd        = access && !wb_req_i.we;
        idx       = wb_req_i.adr[ADR_MSB:ADR_LSB];
        start_cmd = wr && idx == IDX_CTRL && wb_req_i.dat[CTRL_START];
        stop_cmd  = wr && idx == IDX_CTRL && wb_req_i.dat[CTRL_STOP];
        reset_cmd = wr && idx == IDX_CTRL && wb_req_i.dat[CTRL_RESET];
        data_read = rd && idx == IDX_DATA;
    end

    always_comb begin
        next_s = s;
        next_s.ack = access;

        // Register writes
        if (wr && idx == IDX_BIAS) begin
            next_s.bias = wb_req_i.dat[7:0];
        end
        if (wr && idx == IDX_CTRL) begin
            next_s.sw_pdown  = wb_req_i.dat[CTRL_PDOWN];
            next_s.cont_mode = wb_req_i.dat[CTRL_CONT];
        end

        // External clock activity watch
        next_s.ext_clk_q = external_clock_input_i;
        if (external_clock_input_i != s.ext_clk_q) begin
            next_s.idle_cnt     = '0;
            next_s.internal_osc = 1'b0;
        end else if (s.idle_cnt == IDLE_MAX) begin
            next_s.internal_osc = 1'b1;
        end else begin
            next_s.idle_cnt = s.idle_cnt + 1'b1;
        end

        pdown      = s.sw_pdown || !power_down_pin_n_i;
        free_run   = start_pin_i && s.cont_mode;
        new_result = conv_valid_i && s.fsm == ST_CONV;

        // Conversion sequencing
        case (s.fsm)
            ST_IDLE: begin
                if (pdown) begin
                    next_s.fsm = ST_PDOWN;
                end else if (free_run || (!start_pin_i && start_cmd)) begin
                    next_s.fsm = ST_CONV;
                end
            end
            ST_CONV: begin
                if (pdown) begin
                    next_s.fsm = ST_PDOWN;
                end else if (free_run) begin
                    next_s.fsm = ST_CONV;
                end else if (start_pin_i || stop_cmd) begin
                    next_s.fsm = ST_IDLE;
                end else if (new_result && !s.cont_mode) begin
                    next_s.fsm = ST_IDLE;
                end
            end
            ST_PDOWN: begin
                if (!pdown) begin
                    next_s.fsm = ST_IDLE;
                end
            end
            default: begin
                next_s.fsm = ST_IDLE;
            end
        endcase

        // Result buffer; a new result wins over a read that clears ready
        if (new_result) begin
            next_s.result = conv_data_i;
            next_s.ready  = 1'b1;
        end else if (data_read) begin
            next_s.ready = 1'b0;
        end

        // Register reads
        next_s.rdata = '0;
        if (rd) begin
            case (idx)
                IDX_BIAS: next_s.rdata[7:0] = s.bias;
                IDX_CTRL: begin
                    next_s.rdata[CTRL_PDOWN] = s.sw_pdown;
                    next_s.rdata[CTRL_CONT]  = s.cont_mode;
                end
                IDX_STAT: begin
                    next_s.rdata[STAT_READY] = s.ready;
                    next_s.rdata[STAT_CONV]  = s.fsm == ST_CONV;
                    next_s.rdata[STAT_PDOWN] = s.fsm == ST_PDOWN;
                    next_s.rdata[STAT_OSC]   = s.internal_osc;
                    next_s.rdata[STAT_SER]   = !cs_n_i;
                end
                IDX_DATA: next_s.rdata[DATA_W-1:0] = s.result;
                default:  next_s.rdata = '0;
            endcase
        end

        // Analog bias drive, off while powered down
        next_s.bias_drv = '0;
        if (s.fsm != ST_PDOWN) begin
            next_s.bias_drv.level_shift_bias_enable = s.bias[BIAS_VB];
            next_s.bias_drv.burnout_polarity        = s.bias[BIAS_POL];
            case (s.bias[BIAS_MAG_H:BIAS_MAG_L])
                BO_50NA, BO_200NA, BO_1UA, BO_10UA: begin
                    next_s.bias_drv.burnout_magnitude = s.bias[BIAS_MAG_H:BIAS_MAG_L];
                end
                default: begin
                    next_s.bias_drv.burnout_magnitude = BO_OFF;
                end
            endcase
        end

        // Ready pins; dual pin shows data while shifting
        next_s.ready_n = !next_s.ready;
        next_s.dout    = serial_busy_i ? serial_dout_i : !next_s.ready;

        // Reset command and reset pin restore power-on state
        if (reset_cmd || !reset_pin_n_i) begin
            next_s     = ibpo_reset_state();
            next_s.ack = access;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= ibpo_reset_state();
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        wb_rsp_o.ack                  = s.ack;
        wb_rsp_o.dat                  = s.rdata;
        conv_run_o                    = s.fsm == ST_CONV;
        internal_osc_sel_o            = s.internal_osc;
        serial_enable_o               = !cs_n_i;
        power_down_o                  = s.fsm == ST_PDOWN;
        ready_output_n_o              = s.ready_n;
        dual_serial_ready_output_o    = s.dout;
        dual_serial_ready_output_oe_o = !cs_n_i;
        bias_o                        = s.bias_drv;
    end
endmodule // ibpo_top

// ===== rtl/ibpo_pkg.sv
// Constants and carrier types for the input bias and pin option block
package ibpo_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_BIAS = 8'h12;
    localparam logic [7:0] IDX_CTRL = 8'h13;
    localparam logic [7:0] IDX_STAT = 8'h14;
    localparam logic [7:0] IDX_DATA = 8'h15;
    localparam int         ADR_LSB  = 2;
    localparam int         ADR_MSB  = 9;

    localparam logic [7:0] BIAS_RESET = 8'h00;
    localparam int         BIAS_VB    = 4;
    localparam int         BIAS_POL   = 3;
    localparam int         BIAS_MAG_H = 2;
    localparam int         BIAS_MAG_L = 0;

    localparam logic [2:0] BO_OFF    = 3'h0;
    localparam logic [2:0] BO_50NA   = 3'h1;
    localparam logic [2:0] BO_200NA  = 3'h2;
    localparam logic [2:0] BO_1UA    = 3'h3;
    localparam logic [2:0] BO_10UA   = 3'h4;

    // Control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int CTRL_RESET = 2;
    localparam int CTRL_PDOWN = 3;
    localparam int CTRL_CONT  = 4;

    // Status register fields
    localparam int STAT_READY = 0;
    localparam int STAT_CONV  = 1;
    localparam int STAT_PDOWN = 2;
    localparam int STAT_OSC   = 3;
    localparam int STAT_SER   = 4;

    // External clock activity timeout
    localparam int CLK_PERIOD_NS    = 10;
    localparam int CLK_IDLE_NS      = 1000;
    localparam int CLK_IDLE_CYCLES  = CLK_IDLE_NS / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W       = 8;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ibpo_wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ibpo_wb_rsp_type;

    typedef struct packed {
        logic       level_shift_bias_enable;
        logic       burnout_polarity;
        logic [2:0] burnout_magnitude;
    } ibpo_bias_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_PDOWN = 3'b100
    } ibpo_fsm_type;
endpackage

// ===== dv/ibpo_top_properties.sv
// Concurrent checks for the bias and pin option block
`timescale 1ns/10ps
module ibpo_top_properties
    import ibpo_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire ibpo_wb_req_type wb_req_i,
    input wire ibpo_wb_rsp_type wb_rsp_o,
    input wire logic            cs_n_i,
    input wire logic            external_clock_input_i,
    input wire logic            reset_pin_n_i,
    input wire logic            conv_valid_i,
    input wire logic            serial_busy_i,
    input wire logic            serial_dout_i,
    input wire logic            conv_run_o,
    input wire logic            internal_osc_sel_o,
    input wire logic            serial_enable_o,
    input wire logic            power_down_o,
    input wire logic            ready_output_n_o,
    input wire logic            dual_serial_ready_output_oe_o,
    input wire logic            dual_serial_ready_output_o,
    input wire ibpo_bias_type   bias_o
);
    logic [7:0] idle;
    logic       prev;
    // Cycles since the clock pin last moved
    always_ff @(posedge clk_i) begin
        prev <= external_clock_input_i;
        if (rst_i || prev != external_clock_input_i) idle <= 8'h00;
        else if (idle != 8'hC8) idle <= idle + 8'h01;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence taken;
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    endsequence
    chk_ack_next: assert property (taken |=> wb_rsp_o.ack)
        else $error("no ack one cycle after request");
    chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    chk_serial_en: assert property (serial_enable_o == !cs_n_i)
        else $error("serial enable not following select");
    chk_dual_oe: assert property (dual_serial_ready_output_oe_o == !cs_n_i)
        else $error("dual pin drive not following select");
    chk_osc_idle: assert property (idle == 8'(CLK_IDLE_CYCLES + 1) |-> internal_osc_sel_o)
        else $error("idle clock pin without internal oscillator");
    chk_ready_set: assert property (
        conv_valid_i && conv_run_o && reset_pin_n_i |=> !ready_output_n_o)
        else $error("result not flagged ready");
    chk_pin_reset: assert property (
        !reset_pin_n_i |=> !conv_run_o && bias_o == '0 && internal_osc_sel_o)
        else $error("reset pin did not reset state");
    chk_pd_bias: assert property (power_down_o |=> bias_o == '0)
        else $error("bias active in power-down");
    chk_dual_ready: assert property (
        !serial_busy_i |=> dual_serial_ready_output_o == ready_output_n_o)
        else $error("dual pin not showing ready");
    chk_dual_data: assert property (
        serial_busy_i |=> dual_serial_ready_output_o == $past(serial_dout_i))
        else $error("dual pin not showing shifted data");
    chk_mag_legal: assert property (bias_o.burnout_magnitude <= BO_10UA)
        else $error("reserved magnitude on output");
endmodule // ibpo_top_properties

bind ibpo_top ibpo_top_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .cs_n_i(cs_n_i), .external_clock_input_i(external_clock_input_i),
    .reset_pin_n_i(reset_pin_n_i), .conv_valid_i(conv_valid_i), .conv_run_o(conv_run_o),
    .internal_osc_sel_o(internal_osc_sel_o), .serial_enable_o(serial_enable_o),
    .power_down_o(power_down_o), .ready_output_n_o(ready_output_n_o), .bias_o(bias_o),
    .dual_serial_ready_output_oe_o(dual_serial_ready_output_oe_o),
    .dual_serial_ready_output_o(dual_serial_ready_output_o), .serial_busy_i(serial_busy_i),
    .serial_dout_i(serial_dout_i));

// ===== dv/ibpo_host_model.sv
// Host-side pin and conversion source model
`timescale 1ns/10ps
module ibpo_host_model (
    input  wire logic        clk_i,
    input  wire logic        clk_run_i,
    input  wire logic        fire_i,
    input  wire logic        shift_i,
    input  wire logic [23:0] data_i,
    output      logic        ext_clk_o,
    output      logic        conv_valid_o,
    output      logic [23:0] conv_data_o,
    output      logic        busy_o,
    output      logic        dout_o
);
    // Clock pin toggles on request, else held grounded
    always_ff @(posedge clk_i) ext_clk_o <= clk_run_i ? !ext_clk_o : 1'b0;
    assign conv_valid_o = fire_i;
    assign conv_data_o  = data_i;
    assign busy_o       = shift_i;
    assign dout_o       = 1'b1;
endmodule // ibpo_host_model

// ===== dv/ibpo_top_test.sv
// Self-checking bench for the bias and pin option block
`timescale 1ns/10ps
module ibpo_top_test;
    import ibpo_pkg::*;
    logic clk, rst, cs_n, start, rpin_n, pd_n, fire, run, ext, cv, busy, dout, shift;
    logic [23:0] src;
    logic crun, osc, sen, pd, rdy_n, dual, dual_oe;
    logic [23:0] cdat;
    logic [31:0] q;
    ibpo_wb_req_type req;
    ibpo_wb_rsp_type rsp;
    ibpo_bias_type   bias;
    int num_errors = 0;
    int compares = 0;
    ibpo_host_model i_ibpo_host_model (.clk_i(clk), .clk_run_i(run), .fire_i(fire),
        .shift_i(shift), .data_i(src),
        .ext_clk_o(ext), .conv_valid_o(cv), .conv_data_o(cdat), .busy_o(busy), .dout_o(dout));
    ibpo_top i_ibpo_top (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp),
        .cs_n_i(cs_n), .external_clock_input_i(ext), .start_pin_i(start),
        .reset_pin_n_i(rpin_n), .power_down_pin_n_i(pd_n), .serial_busy_i(busy),
        .serial_dout_i(dout), .conv_valid_i(cv), .conv_data_i(cdat), .conv_run_o(crun),
        .internal_osc_sel_o(osc), .serial_enable_o(sen), .power_down_o(pd),
        .ready_output_n_o(rdy_n), .dual_serial_ready_output_o(dual),
        .dual_serial_ready_output_oe_o(dual_oe), .bias_o(bias));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b1, w, {22'h0, a, 2'h0}, 4'hF, d};
        do begin
            @(posedge clk);
        end while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic t_bias;
        rd(IDX_BIAS, 32'h00);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, IDX_BIAS, {27'h0, i[0], i[1], i[2:0]});
            rd(IDX_BIAS, {27'h0, i[0], i[1], i[2:0]});
            chk(32'(bias), {27'h0, i[0], i[1], (i > 4 ? 3'h0 : i[2:0])});
        end
        rd(8'h20, 32'h0);
        cs_n <= 1'b1;
        tick(1);
        chk(32'({sen, dual_oe}), 32'h0);
        cs_n <= 1'b0;
        tick(1);
        chk(32'({sen, dual_oe}), 32'h3);
    endtask
    task automatic t_conv;
        wb(1'b1, IDX_CTRL, 32'h01);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(3);
        chk(32'({rdy_n, crun, dual}), 32'h0);
        shift <= 1'b1;
        tick(2);
        chk(32'(dual), 32'h1);
        shift <= 1'b0;
        tick(2);
        chk(32'(dual), 32'h0);
        rd(IDX_STAT, 32'h19);
        rd(IDX_DATA, 32'hA5C3E1);
        rd(IDX_STAT, 32'h18);
        chk(32'(dual), 32'h1);
        wb(1'b1, IDX_CTRL, 32'h10);
        src <= 24'h5A3C1E;
        start <= 1'b1;
        tick(3);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(3);
        chk(32'({rdy_n, crun}), 32'h1);
        rd(IDX_STAT, 32'h1B);
        start <= 1'b0;
        wb(1'b1, IDX_CTRL, 32'h02);
        rd(IDX_DATA, 32'h5A3C1E);
        chk(32'({rdy_n, crun}), 32'h2);
    endtask
    task automatic t_pd;
        wb(1'b1, IDX_BIAS, 32'h1B);
        wb(1'b1, IDX_CTRL, 32'h08);
        tick(2);
        chk(32'({pd, bias}), 32'h20);
        rd(IDX_STAT, 32'h1C);
        wb(1'b1, IDX_CTRL, 32'h00);
        pd_n <= 1'b0;
        tick(3);
        chk(32'({pd, bias}), 32'h20);
        pd_n <= 1'b1;
        tick(3);
        chk(32'({pd, bias}), 32'h1B);
        rpin_n <= 1'b0;
        tick(1);
        rpin_n <= 1'b1;
        rd(IDX_BIAS, 32'h00);
        wb(1'b1, IDX_BIAS, 32'h0C);
        wb(1'b1, IDX_CTRL, 32'h04);
        rd(IDX_BIAS, 32'h00);
        run <= 1'b1;
        tick(10);
        chk(32'(osc), 32'h0);
        run <= 1'b0;
        tick(110);
        chk(32'(osc), 32'h1);
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        {rst, rpin_n, pd_n} = 3'b111;
        {cs_n, start, fire, run, shift} = 5'h00;
        src = 24'hA5C3E1;
        req = '0;
        tick(12);
        rst <= 1'b0;
        t_bias();
        t_conv();
        t_pd();
        summarize();
    end
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule // ibpo_top_test
